// ===== rtl/rsso_datapath.sv
// Execution datapath for six memory-operand instructions of an 8-bit core.
// Assumes the sequencer presents operands and flags on core_clk and
// writes back accumulator, memory and flags from the registered answer.
//
// Function
// - Rotate right through carry, result to memory
// - Same rotate, result to accumulator, memory kept
// - Accumulator minus operand minus inverted carry
// - Carry clear if negative, set otherwise
// - Subtract updates all six arithmetic flags
// - Memory form of subtract keeps accumulator
// - Decrement memory, write back, skip when zero
// - Skip inserts dummy cycle, three cycles total
// - Nonzero result continues without skip cycle
// - Accumulator decrement form, memory kept, skip zero
`timescale 1ns/1ps
`include "rsso_defines.svh"

module rsso_datapath (
    input  wire logic               core_clk,
    input  wire logic               reset_n,
    input  rsso_pkg::rsso_req_t     req,
    output rsso_pkg::rsso_rsp_t     rsp,
    output logic                    req_ready,
    output logic                    skip,
    output logic                    dummy
);
    import rsso_pkg::*;

    localparam int DW = `RSSO_DATA_W;
    localparam int NW = `RSSO_NIB_W;

    rsso_state_t    state_ff;
    rsso_state_t    nxt_state_ff;
    rsso_rsp_t      rsp_ff;
    rsso_rsp_t      nxt_rsp_ff;
    logic           ready_ff;
    logic           nxt_ready_ff;
    logic           skip_ff;
    logic           nxt_skip_ff;
    logic           dummy_ff;
    logic           nxt_dummy_ff;

    logic           accept;
    logic [DW:0]    diff;
    logic [NW:0]    nib_diff;
    logic [DW-1:0]  dec_val;
    logic [DW-1:0]  rot_val;
    logic           want_skip;

    assign accept = req.valid && ready_ff;

    // Arithmetic shared by the instruction forms
    always_comb begin
        rot_val  = {req.flags.carry, req.mem[DW-1:1]};
        diff     = {1'b0, req.acc} - {1'b0, req.mem}
                 - {{DW{1'b0}}, ~req.flags.carry};
        nib_diff = {1'b0, req.acc[NW-1:0]} - {1'b0, req.mem[NW-1:0]}
                 - {{NW{1'b0}}, ~req.flags.carry};
        dec_val  = req.mem - `RSSO_DEC_STEP;
    end

    // Answer computation
    always_comb begin
        nxt_rsp_ff         = '0;
        nxt_rsp_ff.op      = req.op;
        nxt_rsp_ff.flags   = req.flags;
        want_skip          = 1'b0;
        if (accept) begin
            nxt_rsp_ff.done = 1'b1;
            case (req.op)
                RSSO_OP_ROT_MEM, RSSO_OP_ROT_ACC: begin
                    nxt_rsp_ff.data          = rot_val;
                    nxt_rsp_ff.mem_we        = (req.op == RSSO_OP_ROT_MEM);
                    nxt_rsp_ff.acc_we        = (req.op == RSSO_OP_ROT_ACC);
                    nxt_rsp_ff.flag_we.carry = 1'b1;
                    nxt_rsp_ff.flags.carry   = req.mem[0];
                end
                RSSO_OP_SUB_ACC, RSSO_OP_SUB_MEM: begin
                    nxt_rsp_ff.data   = diff[DW-1:0];
                    nxt_rsp_ff.acc_we = (req.op == RSSO_OP_SUB_ACC);
                    nxt_rsp_ff.mem_we = (req.op == RSSO_OP_SUB_MEM);
                    nxt_rsp_ff.flag_we = '1;
                    // Carry is the inverted borrow
                    nxt_rsp_ff.flags.carry = ~diff[DW];
                    nxt_rsp_ff.flags.half_carry_flag = ~nib_diff[NW];
                    nxt_rsp_ff.flags.zero = (diff[DW-1:0] == `RSSO_ZERO);
                    nxt_rsp_ff.flags.signed_wrap_flag =
                        (req.acc[`RSSO_MSB] != req.mem[`RSSO_MSB]) &&
                        (diff[`RSSO_MSB] != req.acc[`RSSO_MSB]);
                    // Signed greater-or-equal, corrected for wrap
                    nxt_rsp_ff.flags.signed_compare_flag =
                        ~(diff[`RSSO_MSB] ^
                          nxt_rsp_ff.flags.signed_wrap_flag);
                    // Zero across a multi-byte chain of subtractions
                    nxt_rsp_ff.flags.chained_zero_flag =
                        req.flags.chained_zero_flag &&
                        (diff[DW-1:0] == `RSSO_ZERO);
                end
                RSSO_OP_DEC_MEM, RSSO_OP_DEC_ACC: begin
                    nxt_rsp_ff.data   = dec_val;
                    nxt_rsp_ff.mem_we = (req.op == RSSO_OP_DEC_MEM);
                    nxt_rsp_ff.acc_we = (req.op == RSSO_OP_DEC_ACC);
                    want_skip = (dec_val == `RSSO_ZERO);
                end
                default: begin
                    nxt_rsp_ff.done = 1'b0;
                end
            endcase
        end
    end

    // Skip sequencing: dummy slot while the next instruction is fetched
    always_comb begin
        nxt_state_ff = state_ff;
        nxt_skip_ff  = 1'b0;
        case (state_ff)
            RSSO_ST_RUN: begin
                if (want_skip) begin
                    nxt_state_ff = RSSO_ST_SKIP1;
                    nxt_skip_ff  = 1'b1;
                end
            end
            RSSO_ST_SKIP1: begin
                nxt_state_ff = RSSO_ST_SKIP2;
            end
            RSSO_ST_SKIP2: begin
                nxt_state_ff = RSSO_ST_RUN;
            end
            default: begin
                nxt_state_ff = RSSO_ST_RUN;
            end
        endcase
        nxt_ready_ff = (nxt_state_ff == RSSO_ST_RUN);
        nxt_dummy_ff = (nxt_state_ff == RSSO_ST_SKIP2);
    end

    // Answer registers
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff <= nxt_rsp_ff;
        end
    end

    // Skip sequencing registers
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_ff <= RSSO_ST_RUN;
            ready_ff <= `RSSO_RST_READY;
            skip_ff  <= 1'b0;
            dummy_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state_ff;
            ready_ff <= nxt_ready_ff;
            skip_ff  <= nxt_skip_ff;
            dummy_ff <= nxt_dummy_ff;
        end
    end

    assign rsp       = rsp_ff;
    assign req_ready = ready_ff;
    assign skip      = skip_ff;
    assign dummy     = dummy_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    logic ok_rot;
    logic ok_dec;
    logic ok_sub;
    int   sdiff;
    assign ok_rot = accept && (req.op == RSSO_OP_ROT_MEM);
    assign ok_dec = accept && (req.op == RSSO_OP_DEC_MEM ||
                               req.op == RSSO_OP_DEC_ACC);
    assign ok_sub = accept && (req.op == RSSO_OP_SUB_ACC ||
                               req.op == RSSO_OP_SUB_MEM);
    // True signed difference, wide enough to show a signed wrap
    assign sdiff = int'($signed(req.acc)) - int'($signed(req.mem))
                 - int'(!req.flags.carry);

    // Checks follow a request to its answer one cycle later, test the answer and skip outputs in the cycle they appear, or trace a skip through its dummy slot

    AST_ROT_MEM: assert property (
        ok_rot |=> rsp.done && rsp.mem_we && !rsp.acc_we &&
            rsp.data == {$past(req.flags.carry), $past(req.mem[7:1])} &&
            rsp.flags.carry == $past(req.mem[0]) &&
            rsp.flag_we == 6'b000100)
        else $error("rotate to memory wrong");

    AST_ROT_ACC: assert property (
        accept && req.op == RSSO_OP_ROT_ACC
        |=> rsp.acc_we && !rsp.mem_we &&
            rsp.data == {$past(req.flags.carry), $past(req.mem[7:1])})
        else $error("rotate to accumulator wrong");

    AST_SUB_DATA: assert property (
        accept && req.op == RSSO_OP_SUB_ACC |=> rsp.acc_we && !rsp.mem_we &&
            rsp.data == 8'($past(req.acc) - $past(req.mem)
                           - {7'h0, ~$past(req.flags.carry)}))
        else $error("subtract result wrong");

    AST_SUB_CARRY: assert property (
        accept && (req.op == RSSO_OP_SUB_ACC || req.op == RSSO_OP_SUB_MEM)
        |=> rsp.flags.carry == ({1'b0, $past(req.acc)} >=
            9'({1'b0, $past(req.mem)}) + {8'h0, ~$past(req.flags.carry)}))
        else $error("subtract carry wrong");

    AST_SUB_FLAGS: assert property (
        rsp.done && (rsp.op == RSSO_OP_SUB_ACC || rsp.op == RSSO_OP_SUB_MEM)
        |-> rsp.flag_we == 6'h3f &&
            rsp.flags.zero == (rsp.data == 8'h00))
        else $error("subtract flags wrong");

    AST_SUB_MEM: assert property (
        rsp.done && rsp.op == RSSO_OP_SUB_MEM |-> rsp.mem_we && !rsp.acc_we)
        else $error("subtract to memory wrong");

    AST_DEC_MEM: assert property (
        accept && req.op == RSSO_OP_DEC_MEM |=> rsp.mem_we &&
            rsp.data == 8'($past(req.mem) - 8'h01) &&
            skip == (rsp.data == 8'h00))
        else $error("decrement to memory wrong");

    AST_SKIP_SEQ: assert property (
        skip |-> !req_ready && !dummy ##1 !req_ready && dummy
                 ##1 req_ready && !dummy)
        else $error("skip sequence wrong");

    AST_NO_SKIP: assert property (
        ok_dec && req.mem != 8'h01 |=> !skip && req_ready)
        else $error("skip without zero result");

    AST_DEC_ACC: assert property (
        accept && req.op == RSSO_OP_DEC_ACC |=> rsp.acc_we && !rsp.mem_we &&
            rsp.data == 8'($past(req.mem) - 8'h01) &&
            skip == (rsp.data == 8'h00))
        else $error("decrement to accumulator wrong");

    AST_DEC_FLAGS: assert property (
        ok_dec |=> rsp.flag_we == 6'h00)
        else $error("decrement changed flags");

    AST_DEC_KEEP: assert property (
        ok_dec |=> rsp.done && rsp.flags == $past(req.flags))
        else $error("decrement altered flag values");

    AST_SKIP_ZERO: assert property (
        skip |-> rsp.done && rsp.data == 8'h00 && rsp.flag_we == 6'h00)
        else $error("skip without a zero decrement");

    AST_ROT_FLAGS: assert property (
        accept && req.op == RSSO_OP_ROT_ACC
        |=> rsp.flags.carry == $past(req.mem[0]) &&
            rsp.flag_we == 6'b000100)
        else $error("rotate to accumulator carry wrong");

    AST_SUB_MEM_DATA: assert property (
        accept && req.op == RSSO_OP_SUB_MEM
        |=> rsp.data == 8'($past(sdiff)))
        else $error("subtract to memory result wrong");

    AST_SUB_HALF: assert property (
        ok_sub |=> rsp.flags.half_carry_flag ==
            ({1'b0, $past(req.acc[3:0])} >=
             {1'b0, $past(req.mem[3:0])} +
             {4'h0, ~$past(req.flags.carry)}))
        else $error("subtract half carry wrong");

    AST_SUB_WRAP: assert property (
        ok_sub |=> rsp.flags.signed_wrap_flag ==
            ($past(sdiff) > 127 || $past(sdiff) < -128))
        else $error("subtract overflow flag wrong");

    AST_SUB_SIGN: assert property (
        ok_sub |=> rsp.flags.signed_compare_flag == ($past(sdiff) >= 0))
        else $error("subtract signed compare flag wrong");

    AST_SUB_ZERO: assert property (
        ok_sub |=> rsp.flags.zero ==
            (8'($past(sdiff)) == 8'h00))
        else $error("subtract zero flag wrong");

    AST_SUB_CHAIN: assert property (
        ok_sub |=> rsp.flags.chained_zero_flag ==
            ($past(req.flags.chained_zero_flag) &&
             8'($past(sdiff)) == 8'h00))
        else $error("subtract chained zero flag wrong");

    AST_IDLE: assert property (
        !accept |=> !rsp.done && !rsp.acc_we && !rsp.mem_we && !skip &&
            rsp.flag_we == 6'h00 && rsp.data == 8'h00)
        else $error("answer without a taken request");

    AST_BAD_OP: assert property (
        accept && !(req.op inside {RSSO_OP_ROT_MEM, RSSO_OP_ROT_ACC,
            RSSO_OP_SUB_ACC, RSSO_OP_SUB_MEM, RSSO_OP_DEC_MEM,
            RSSO_OP_DEC_ACC}) |=> !rsp.done && !skip && req_ready)
        else $error("undefined operation answered");

    AST_DUMMY: assert property (
        dummy |-> $past(skip) && !req_ready)
        else $error("dummy slot without a skip");

    COV_SKIP: cover property (ok_dec ##1 skip ##2 req_ready);
    COV_SUB_NEG: cover property (
        accept && req.op == RSSO_OP_SUB_ACC ##1 !rsp.flags.carry);
    COV_ROT: cover property (ok_rot);
    COV_DEC_NZ: cover property (ok_dec ##1 !skip);
    COV_SUB_WRAP: cover property (ok_sub ##1 rsp.flags.signed_wrap_flag);

endmodule

// ===== rtl/rsso_defines.svh
// Constants for the rotate / subtract-with-borrow / decrement-skip datapath.
// Assumes inclusion by bare name from the package and the datapath.
`ifndef RSSO_DEFINES_SVH
`define RSSO_DEFINES_SVH

`define RSSO_DATA_W        8
`define RSSO_MSB           7
`define RSSO_NIB_W         4
`define RSSO_DEC_STEP      8'h01
`define RSSO_ZERO          8'h00
`define RSSO_SKIP_CYCLES   3
`define RSSO_RST_DATA      8'h00
`define RSSO_RST_READY     1'b1

`endif

// ===== rtl/rsso_pkg.sv
// Types for the rotate / subtract-with-borrow / decrement-skip datapath.
// Assumes rsso_defines.svh is on the include path.
`include "rsso_defines.svh"

package rsso_pkg;

    typedef enum logic [2:0] {
        RSSO_OP_ROT_MEM = 3'h0,
        RSSO_OP_ROT_ACC = 3'h1,
        RSSO_OP_SUB_ACC = 3'h2,
        RSSO_OP_SUB_MEM = 3'h3,
        RSSO_OP_DEC_MEM = 3'h4,
        RSSO_OP_DEC_ACC = 3'h5
    } rsso_op_t;

    typedef enum logic [2:0] {
        RSSO_ST_RUN   = 3'b001,
        RSSO_ST_SKIP1 = 3'b010,
        RSSO_ST_SKIP2 = 3'b100
    } rsso_state_t;

    // Status flags; also used as a per-flag write mask
    typedef struct packed {
        logic signed_wrap_flag;
        logic zero;
        logic half_carry_flag;
        logic carry;
        logic signed_compare_flag;
        logic chained_zero_flag;
    } rsso_flags_t;

    typedef struct packed {
        logic                      valid;
        rsso_op_t                  op;
        logic [`RSSO_DATA_W-1:0]   acc;
        logic [`RSSO_DATA_W-1:0]   mem;
        rsso_flags_t               flags;
    } rsso_req_t;

    typedef struct packed {
        logic                      done;
        rsso_op_t                  op;
        logic                      acc_we;
        logic                      mem_we;
        logic [`RSSO_DATA_W-1:0]   data;
        rsso_flags_t               flag_we;
        rsso_flags_t               flags;
    } rsso_rsp_t;

endpackage

// ===== sim/rsso_seq_model.sv
// Sequencer and data memory model facing the rotate/subtract/decrement path.
// Assumes the bench loads operands, then issues; writebacks land on done.
`timescale 1ns/1ps

module rsso_seq_model (
    input  wire logic            core_clk,
    input  wire logic            reset_n,
    input  wire logic            load,
    input  wire logic [7:0]      ld_acc,
    input  wire logic [7:0]      ld_mem,
    input  wire logic            ld_c,
    input  wire logic            issue,
    input  rsso_pkg::rsso_op_t   issue_op,
    input  rsso_pkg::rsso_rsp_t  rsp,
    output rsso_pkg::rsso_req_t  req,
    output logic [7:0]           acc,
    output logic [7:0]           mem
);
    import rsso_pkg::*;

    rsso_flags_t flg_ff;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            acc    <= 8'h00;
            mem    <= 8'h00;
            flg_ff <= '0;
        end else if (load) begin
            acc    <= ld_acc;
            mem    <= ld_mem;
            flg_ff <= '0;
            flg_ff.carry <= ld_c;
            // A load opens a fresh multi-byte chain: zero so far
            flg_ff.chained_zero_flag <= 1'b1;
        end else if (rsp.done) begin
            // Only the flags in the write mask change
            if (rsp.acc_we) acc <= rsp.data;
            if (rsp.mem_we) mem <= rsp.data;
            flg_ff <= (flg_ff & ~rsp.flag_we) | (rsp.flags & rsp.flag_we);
        end
    end

    assign req = '{valid: issue, op: issue_op, acc: acc, mem: mem,
                   flags: flg_ff};
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the rotate/subtract/decrement datapath.
// Assumes rtl/ package and defines are compiled first.
`timescale 1ns/1ps

module testbench;
    import rsso_pkg::*;

    typedef struct packed {
        rsso_op_t   op;
        logic [7:0] a;
        logic [7:0] m;
        logic       c;
        logic [7:0] d;
        logic       co;
        logic       z;
        logic       sk;
        logic [5:0] f;
    } rsso_row_t;

    logic        core_clk = 0;
    logic        reset_n = 0;
    logic        load = 0;
    logic [7:0]  ld_acc = 8'h00;
    logic [7:0]  ld_mem = 8'h00;
    logic        ld_c = 0;
    logic        issue = 0;
    rsso_op_t    issue_op = RSSO_OP_ROT_MEM;
    rsso_req_t   req;
    rsso_rsp_t   rsp;
    logic        req_ready;
    logic        skip;
    logic        dummy;
    logic [7:0]  acc;
    logic [7:0]  mem;
    int          fail_count = 0;
    int          checked = 0;
    int          cycles = 0;
    logic        md;
    rsso_row_t   rows [10];

    rsso_datapath DUT (.core_clk(core_clk), .reset_n(reset_n), .req(req),
        .rsp(rsp), .req_ready(req_ready), .skip(skip), .dummy(dummy));
    rsso_seq_model seq (.core_clk(core_clk), .reset_n(reset_n),
        .load(load), .ld_acc(ld_acc), .ld_mem(ld_mem), .ld_c(ld_c),
        .issue(issue), .issue_op(issue_op), .rsp(rsp), .req(req),
        .acc(acc), .mem(mem));

    initial begin
        forever #4 core_clk = ~core_clk;
    end

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            finish_test();
        end
    end

    initial begin
        rows = '{
            '{RSSO_OP_ROT_MEM, 8'h00, 8'h03, 1, 8'h81, 1, 0, 0, 6'h05},
            '{RSSO_OP_ROT_ACC, 8'h00, 8'h81, 0, 8'h40, 1, 0, 0, 6'h05},
            '{RSSO_OP_SUB_ACC, 8'h05, 8'h07, 1, 8'hfe, 0, 0, 0, 6'h00},
            '{RSSO_OP_SUB_ACC, 8'h07, 8'h07, 1, 8'h00, 1, 1, 0, 6'h1f},
            '{RSSO_OP_SUB_MEM, 8'h10, 8'h05, 0, 8'h0a, 1, 0, 0, 6'h06},
            '{RSSO_OP_SUB_ACC, 8'h80, 8'h01, 1, 8'h7f, 1, 0, 0, 6'h24},
            '{RSSO_OP_DEC_MEM, 8'h00, 8'h01, 1, 8'h00, 1, 0, 1, 6'h05},
            '{RSSO_OP_DEC_MEM, 8'h00, 8'h00, 1, 8'hff, 1, 0, 0, 6'h05},
            '{RSSO_OP_DEC_ACC, 8'h00, 8'h01, 1, 8'h00, 1, 0, 1, 6'h05},
            '{RSSO_OP_DEC_ACC, 8'h00, 8'h05, 1, 8'h04, 1, 0, 0, 6'h05}};
        repeat (12) @(negedge core_clk);
        chk(rsp, '0);
        chk({req_ready, skip, dummy}, 3'b100);
        reset_n = 1;
        foreach (rows[i]) begin
            md = rows[i].op inside {RSSO_OP_ROT_MEM, RSSO_OP_SUB_MEM,
                                    RSSO_OP_DEC_MEM};
            @(negedge core_clk);
            load = 1;
            ld_acc = rows[i].a;
            ld_mem = rows[i].m;
            ld_c = rows[i].c;
            @(negedge core_clk);
            load = 0;
            issue = 1;
            issue_op = rows[i].op;
            @(negedge core_clk);
            issue = 0;
            chk({rsp.done, rsp.data}, {1'b1, rows[i].d});
            chk(rsp.flags.carry, rows[i].co);
            chk(rsp.flags.zero, rows[i].z);
            chk(skip, rows[i].sk);
            chk({rsp.acc_we, rsp.mem_we}, {~md, md});
            chk(rsp.flag_we, rows[i].op inside {RSSO_OP_SUB_ACC,
                RSSO_OP_SUB_MEM} ? 6'h3f : rows[i].op inside
                {RSSO_OP_DEC_MEM, RSSO_OP_DEC_ACC} ? 6'h00 : 6'h04);
            chk(rsp.flags, rows[i].f);
            chk(rsp.op, rows[i].op);
            @(negedge core_clk);
            chk({acc, mem}, md ? {rows[i].a, rows[i].d}
                               : {rows[i].d, rows[i].m});
            for (int n = 0; n < 8 && req_ready !== 1'b1; n++)
                @(negedge core_clk);
        end
        // Skipping decrement with a request held through the dummy slot
        @(negedge core_clk);
        load = 1;
        ld_mem = 8'h01;
        @(negedge core_clk);
        load = 0;
        issue = 1;
        issue_op = RSSO_OP_DEC_MEM;
        @(negedge core_clk);
        issue_op = RSSO_OP_ROT_MEM;
        chk({rsp.done, skip, req_ready}, 3'b110);
        @(negedge core_clk);
        chk({rsp.done, dummy, req_ready, mem}, {3'b010, 8'h00});
        @(negedge core_clk);
        issue = 0;
        chk({rsp.done, dummy, req_ready}, 3'b001);
        @(negedge core_clk);
        chk(rsp.done, 1'b0);
        // Reset in the middle of a skip clears the sequencing state
        load = 1;
        ld_mem = 8'h01;
        @(negedge core_clk);
        load = 0;
        issue = 1;
        issue_op = RSSO_OP_DEC_MEM;
        @(negedge core_clk);
        issue = 0;
        reset_n = 0;
        chk(skip, 1'b1);
        @(negedge core_clk);
        chk({rsp.done, skip, dummy, req_ready, mem},
            {4'b0001, 8'h00});
        reset_n = 1;
        @(negedge core_clk);
        // Undefined operation code is taken but never answered
        issue = 1;
        issue_op = rsso_op_t'(3'h6);
        @(negedge core_clk);
        issue = 0;
        chk({rsp.done, rsp.acc_we, rsp.mem_we, skip, req_ready, rsp.data},
            {5'b00001, 8'h00});
        finish_test();
    end
endmodule
